// file: dv/dsd_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsd_cpu_model import dsd_pkg::*; (
  input wire logic clock_i, // CPU clock
  input wire logic busy_i, // Stall from decoder
  input wire dsd_rsp_t rsp_i, // Answer from decoder
  output var dsd_req_t req_o // Request to decoder
);
  initial req_o = '0;

  // Entered just after an edge; holds the request until the taking edge
  task automatic access(input dsd_req_t r, output dsd_rsp_t a, output int lat);
    int n;
    dsd_req_t q;
    // One idle edge between calls, so release and next request never share a step
    @(posedge clock_i) #1;
    req_o = r;
    for (n = 0; n < 50 && busy_i !== 1'h0; n++) @(posedge clock_i) #1;
    @(posedge clock_i) #1;
    // Released fields flip so stale values are never mistaken for live ones
    q = ~r;
    q.valid = 1'h0;
    req_o = q;
    for (n = 1; n < 9 && rsp_i.valid !== 1'h1; n++) @(posedge clock_i) #1;
    a = rsp_i;
    lat = n;
  endtask : access
endmodule : dsd_cpu_model
`default_nettype wire

// file: dv/dsd_decoder_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dsd_decoder_assertions import dsd_pkg::*; #(
  parameter int unsigned SRAM_BYTES = SRAM_BYTES_DEF
) (
  input wire logic clock_i, // CPU clock
  input wire logic rst_n_i, // Reset, active low
  input wire dsd_req_t req_i, // Request
  input wire dsd_rsp_t rsp_o, // Answer
  input wire logic busy_o, // Stall
  input wire dsd_region_t region_o, // Last region
  input wire logic nv_busy_o // Write active
);
  localparam logic [15:0] SRAM_END = 16'(SRAM_BASE + SRAM_BYTES - 1);
  logic take, dir, ctl_w, arm_set;
  logic [2:0] arm_cnt_r;
  assign take = req_i.valid && !busy_o;
  assign dir = take && !req_i.io_form && req_i.mode == AM_DIRECT;
  assign ctl_w = take && (req_i.io_form ? req_i.io_addr == IO_NV_CTRL
                                        : dir && req_i.addr == 16'h003F);
  assign arm_set = ctl_w && ((req_i.bitop == BOP_NONE && req_i.write && req_i.wdata[CTL_ARM])
                   || (req_i.bitop == BOP_SET && req_i.bit_idx == 3'h2));
  // Loose arm window tracker
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) arm_cnt_r <= 3'h0;
    else if (arm_set) arm_cnt_r <= 3'h5;
    else if (arm_cnt_r != 3'h0) arm_cnt_r <= arm_cnt_r - 3'h1;
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_regf_route:
    assert property (dir && req_i.addr <= REGF_END |=> region_o == RG_REGF && rsp_o.valid)
    else $error("register file access misrouted");
  a_stdio_route:
    assert property (dir && req_i.addr inside {[16'h0020:16'h005F]} |=> region_o == RG_STDIO)
    else $error("standard io access misrouted");
  a_extio_read:
    assert property (dir && !req_i.write && req_i.addr inside {[16'h0060:16'h00FF]}
      |=> region_o == RG_EXTIO && rsp_o.valid && rsp_o.rdata == 8'h00)
    else $error("extended io read wrong");
  a_ioform_map:
    assert property (take && req_i.io_form && req_i.bitop == BOP_NONE |=> region_o == RG_STDIO)
    else $error("io form not mapped to standard io");
  a_sram_timing:
    assert property (dir && req_i.addr inside {[SRAM_BASE:SRAM_END]}
      |=> busy_o && !rsp_o.valid && region_o == RG_SRAM ##1 rsp_o.valid && !busy_o)
    else $error("sram access not two cycles");
  a_sram_bound:
    assert property (dir && req_i.addr > SRAM_END |=> region_o == RG_NONE)
    else $error("address past sram end decoded");
  a_nvrd_stall:
    assert property (ctl_w && req_i.io_form && req_i.write && req_i.bitop == BOP_NONE
      && req_i.wdata == 8'h01 && !nv_busy_o |=> busy_o [*4] ##1 !busy_o)
    else $error("read stall not four cycles");
  a_nvwr_stall:
    assert property ($rose(nv_busy_o) |-> busy_o ##1 busy_o ##1 !busy_o)
    else $error("write stall not two cycles");
  a_arm_needed:
    assert property ($rose(nv_busy_o) |-> arm_cnt_r != 3'h0)
    else $error("write started without arming");
  a_bitop_range:
    assert property (take && req_i.io_form && req_i.bitop != BOP_NONE
      && req_i.io_addr > IO_BIT_END |=> rsp_o.valid && !rsp_o.skip)
    else $error("bit op outside range acted");
endmodule : dsd_decoder_assertions

bind dsd_decoder dsd_decoder_assertions #(.SRAM_BYTES(SRAM_BYTES)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .rsp_o(rsp_o),
  .busy_o(busy_o), .region_o(region_o), .nv_busy_o(nv_busy_o));
`default_nettype wire

// file: dv/dsd_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dsd_decoder_tb import dsd_pkg::*; ();
  logic clock_i, rst_n_i, busy, nv_busy;
  dsd_req_t req;
  dsd_rsp_t rsp;
  dsd_region_t region;
  int errors = 0;
  int n_compared = 0;

  dsd_decoder #(.NV_ATOM_CYC(20), .NV_SPL_CYC(10)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .req_i(req), .rsp_o(rsp), .busy_o(busy), .region_o(region), .nv_busy_o(nv_busy));
  dsd_cpu_model cpu (.clock_i(clock_i), .busy_i(busy), .rsp_i(rsp), .req_o(req));

  initial begin
    clock_i = 1'h0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic chki(string nm, int e, int g);
    n_compared++;
    if (g != e) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chki

  function automatic dsd_req_t dq(logic w, logic [15:0] ad, logic [7:0] wd);
    dq = '0;
    dq.valid = 1'h1;
    dq.write = w;
    dq.addr = ad;
    dq.wdata = wd;
    dq.mode = AM_DIRECT;
  endfunction : dq

  function automatic dsd_req_t iq(logic w, logic [5:0] ia, logic [7:0] wd, dsd_bitop_t b,
                                  logic [2:0] ix);
    iq = dq(w, 16'h0000, wd);
    iq.io_form = 1'h1;
    iq.io_addr = ia;
    iq.bitop = b;
    iq.bit_idx = ix;
  endfunction : iq

  task automatic acc(input dsd_req_t r, output logic [7:0] d);
    dsd_rsp_t a;
    int l;
    cpu.access(r, a, l);
    d = a.rdata;
  endtask : acc

  task automatic wr(logic [15:0] ad, logic [7:0] v);
    logic [7:0] d;
    acc(dq(1'h1, ad, v), d);
  endtask : wr

  task automatic rdc(string nm, logic [15:0] ad, logic [7:0] e);
    logic [7:0] d;
    acc(dq(1'h0, ad, 8'h00), d);
    chk(nm, e, d);
  endtask : rdc

  task automatic stall(output int n);
    for (n = 0; n < 50 && busy === 1'h1; n++) @(posedge clock_i) #1;
  endtask : stall

  task automatic nvwr(logic [7:0] v, logic [7:0] md);
    logic [7:0] d;
    int n;
    acc(iq(1'h1, IO_NV_DATA, v, BOP_NONE, 3'h0), d);
    acc(iq(1'h1, IO_NV_CTRL, md | 8'h04, BOP_NONE, 3'h0), d); // Arm, reserved bits zero
    acc(iq(1'h1, IO_NV_CTRL, md | 8'h02, BOP_NONE, 3'h0), d);
    stall(n);
    chki("wr_stall", 2, n);
    chk("wr_busy", 1, nv_busy);
  endtask : nvwr

  task automatic wt_nv();
    int n;
    for (n = 0; n < 100 && nv_busy !== 1'h0; n++) @(posedge clock_i) #1;
    chk("nv_done", 0, nv_busy);
  endtask : wt_nv

  task automatic nvrd(string nm, logic [7:0] e);
    logic [7:0] d;
    acc(iq(1'h1, IO_NV_CTRL, 8'h01, BOP_NONE, 3'h0), d);
    rdc(nm, 16'h0040, e);
  endtask : nvrd

  task automatic t_map();
    dsd_rsp_t a;
    int l;
    wr(16'h0005, 8'hA5);
    rdc("r5", 16'h0005, 8'hA5);
    cpu.access(dq(1'h0, 16'h0005, 8'h00), a, l);
    chki("regf_lat", 1, l);
    cpu.access(dq(1'h0, 16'h0100, 8'h00), a, l);
    chki("sram_lat", 2, l);
    wr(16'h04FF, 8'h6B);
    rdc("sram_end", 16'h04FF, 8'h6B);
    rdc("past_end", 16'h0500, 8'h00);
    wr(16'h0080, 8'hFF);
    rdc("ext_io", 16'h0080, 8'h00);
    chk("region", RG_EXTIO, region);
    $display("test map done");
  endtask : t_map

  task automatic t_ptr();
    dsd_req_t r;
    logic [7:0] d;
    wr(16'h001C, 8'h00);
    wr(16'h001D, 8'h01);
    r = dq(1'h1, 16'h0000, 8'h3C);
    r.mode = AM_POSTINC;
    r.ptr = PTR_Y;
    acc(r, d);
    rdc("y_inc", 16'h001C, 8'h01);
    rdc("postinc", 16'h0100, 8'h3C);
    r.mode = AM_DISP;
    r.disp = 6'h3F;
    r.wdata = 8'h77;
    acc(r, d);
    rdc("disp", 16'h0140, 8'h77);
    wr(16'h001E, 8'h41);
    wr(16'h001F, 8'h01);
    r = dq(1'h0, 16'h0000, 8'h00);
    r.mode = AM_PREDEC;
    r.ptr = PTR_Z;
    acc(r, d);
    chk("predec", 8'h77, d);
    rdc("z_dec", 16'h001E, 8'h40);
    $display("test ptr done");
  endtask : t_ptr

  task automatic t_io();
    dsd_rsp_t a;
    logic [7:0] d;
    int l;
    acc(iq(1'h1, IO_GPR, 8'h5A, BOP_NONE, 3'h0), d);
    rdc("io_map", 16'h003D, 8'h5A);
    acc(iq(1'h1, 6'h30, 8'hFF, BOP_NONE, 3'h0), d);
    rdc("unmapped", 16'h0050, 8'h00);
    acc(iq(1'h1, IO_GPR, 8'h00, BOP_CLEAR, 3'h1), d);
    rdc("bclr", 16'h003D, 8'h58);
    acc(iq(1'h1, IO_GPR, 8'h00, BOP_SET, 3'h0), d);
    rdc("bset", 16'h003D, 8'h59);
    cpu.access(iq(1'h0, IO_GPR, 8'h00, BOP_SKIP_SET, 3'h4), a, l);
    chk("skip_set", 1, a.skip);
    cpu.access(iq(1'h0, IO_GPR, 8'h00, BOP_SKIP_CLEAR, 3'h4), a, l);
    chk("skip_clr", 0, a.skip);
    acc(iq(1'h1, IO_NV_DATA, 8'h00, BOP_SET, 3'h0), d);
    rdc("bit_range", 16'h0040, 8'h00);
    $display("test io done");
  endtask : t_io

  task automatic t_nv();
    logic [7:0] d;
    int n;
    acc(iq(1'h1, IO_NV_ALO, 8'h05, BOP_NONE, 3'h0), d);
    acc(iq(1'h1, IO_NV_CTRL, 8'h02, BOP_NONE, 3'h0), d);
    stall(n);
    chki("no_arm", 0, n);
    acc(iq(1'h1, IO_NV_CTRL, 8'h04, BOP_NONE, 3'h0), d);
    repeat (5) @(posedge clock_i);
    #1 acc(iq(1'h1, IO_NV_CTRL, 8'h02, BOP_NONE, 3'h0), d);
    chk("arm_expired", 0, nv_busy);
    nvwr(8'hC3, 8'h00);
    wt_nv();
    rdc("trig_clr", 16'h003F, 8'h00);
    rdc("done_flag", 16'h003C, 8'h01);
    acc(iq(1'h1, IO_FLAGS, 8'h00, BOP_CLEAR, 3'h7), d);
    rdc("flag_kept", 16'h003C, 8'h01);
    wr(16'h003C, 8'h00);
    rdc("w0_kept", 16'h003C, 8'h01);
    wr(16'h003C, 8'h01);
    rdc("w1_clr", 16'h003C, 8'h00);
    wr(16'h0040, 8'h00);
    acc(iq(1'h1, IO_NV_CTRL, 8'h01, BOP_NONE, 3'h0), d);
    stall(n);
    chki("rd_stall", 4, n);
    rdc("nv_read", 16'h0040, 8'hC3);
    $display("test nv done");
  endtask : t_nv

  task automatic t_rst();
    logic [7:0] d;
    nvwr(8'h3E, 8'h00);
    rst_n_i = 1'h0;
    repeat (2) @(posedge clock_i);
    #1 rst_n_i = 1'h1;
    chk("rst_keep", 1, nv_busy);
    rdc("gpr_rst", 16'h003D, 8'h00);
    wt_nv();
    acc(iq(1'h1, IO_NV_CTRL, 8'h01, BOP_NONE, 3'h0), d);
    rdc("rst_write", 16'h0040, 8'h3E);
    // Erase-only then write-only: old byte ANDed with new data
    nvwr(8'h00, 8'h10);
    wt_nv();
    nvrd("erase", 8'hFF);
    nvwr(8'h0F, 8'h20);
    wt_nv();
    nvrd("wr_only", 8'h0F);
    $display("test rst done");
  endtask : t_rst

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial begin
    rst_n_i = 1'h0;
    repeat (5) @(posedge clock_i);
    #1 rst_n_i = 1'h1;
    t_map();
    t_ptr();
    t_io();
    t_nv();
    t_rst();
    summarize();
  end

  initial begin
    #32000;
    errors++;
    summarize();
  end
endmodule : dsd_decoder_tb
`default_nettype wire

// file: pkg/dsd_pkg.sv
`default_nettype none
package dsd_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned NV_ATOMIC_US = 3400;
  localparam int unsigned NV_SPLIT_US = 1800;
  localparam int unsigned NV_ATOMIC_CYC = NV_ATOMIC_US * CLK_MHZ;
  localparam int unsigned NV_SPLIT_CYC = NV_SPLIT_US * CLK_MHZ;
  localparam int unsigned NVT_W_DEF = 20;
  localparam logic [2:0] ARM_CYC = 3'h4;
  localparam logic [2:0] NV_RD_STALL = 3'h4;
  localparam logic [2:0] NV_WR_STALL = 3'h2;

  // Data space map
  localparam logic [15:0] REGF_END = 16'h001F;
  localparam logic [15:0] STDIO_BASE = 16'h0020;
  localparam logic [15:0] STDIO_END = 16'h005F;
  localparam logic [15:0] EXTIO_END = 16'h00FF;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam int unsigned SRAM_BYTES_DEF = 1024;
  localparam int unsigned NV_BYTES_DEF = 512;
  localparam logic [15:0] IO_DATA_OFS = 16'h0020;
  localparam logic [5:0] IO_BIT_END = 6'h1F;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // I/O register addresses (I/O-instruction numbering)
  localparam logic [5:0] IO_FLAGS = 6'h1C;
  localparam logic [5:0] IO_GPR = 6'h1D;
  localparam logic [5:0] IO_NV_CTRL = 6'h1F;
  localparam logic [5:0] IO_NV_DATA = 6'h20;
  localparam logic [5:0] IO_NV_ALO = 6'h21;
  localparam logic [5:0] IO_NV_AHI = 6'h22;
  localparam int unsigned NV_ADDR_W = 11;

  // Field positions
  localparam int unsigned CTL_READ = 0;
  localparam int unsigned CTL_TRIG = 1;
  localparam int unsigned CTL_ARM = 2;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_MODE_HI = 5;
  localparam int unsigned FLG_DONE = 0;

  // Reset values
  localparam logic [7:0] GPR_RST = 8'h00;
  localparam logic [7:0] NV_DATA_RST = 8'h00;
  localparam logic [1:0] NV_MODE_RST = 2'h0;

  typedef enum logic [1:0] {NVM_ATOMIC, NVM_ERASE, NVM_WRITE, NVM_RSVD} dsd_nvmode_t;
  typedef enum logic [2:0] {AM_DIRECT, AM_INDIRECT, AM_DISP, AM_PREDEC, AM_POSTINC} dsd_amode_t;
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} dsd_ptr_t;
  typedef enum logic [2:0] {BOP_NONE, BOP_SET, BOP_CLEAR, BOP_SKIP_SET, BOP_SKIP_CLEAR} dsd_bitop_t;
  typedef enum logic [2:0] {RG_REGF, RG_STDIO, RG_EXTIO, RG_SRAM, RG_NONE} dsd_region_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic io_form;
    dsd_amode_t mode;
    dsd_ptr_t ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [5:0] io_addr;
    logic [7:0] wdata;
    dsd_bitop_t bitop;
    logic [2:0] bit_idx;
  } dsd_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic skip;
  } dsd_rsp_t;
endpackage : dsd_pkg
`default_nettype wire

// file: verilog/dsd_agen.sv
`timescale 1ns/1ns
`default_nettype none
module dsd_agen import dsd_pkg::*; #(
  parameter int unsigned SRAM_BYTES = SRAM_BYTES_DEF
) (
  input wire dsd_req_t req_i, // Access request
  input wire logic [47:0] ptrs_i, // R31..R26 packed
  output logic [15:0] addr_o, // Effective data address
  output dsd_region_t region_o, // Decoded region
  output logic ptr_we_o, // Pointer pair update
  output logic [4:0] ptr_idx_o, // Low register of pair
  output logic [15:0] ptr_nxt_o // New pointer value
);
  localparam logic [15:0] SRAM_END = SRAM_BASE + 16'(SRAM_BYTES - 1);
  logic [15:0] ptr;

  always_comb begin
    unique case (req_i.ptr)
      PTR_X: begin
        ptr = ptrs_i[15:0];
        ptr_idx_o = PTR_X_LO;
      end
      PTR_Y: begin
        ptr = ptrs_i[31:16];
        ptr_idx_o = PTR_Y_LO;
      end
      default: begin
        ptr = ptrs_i[47:32];
        ptr_idx_o = PTR_Z_LO;
      end
    endcase
    ptr_we_o = 1'b0;
    ptr_nxt_o = ptr;
    addr_o = req_i.addr;
    if (req_i.io_form) begin
      addr_o = {10'h000, req_i.io_addr} + IO_DATA_OFS; // [RL9] [RL3]
    end else begin
      unique case (req_i.mode)
        AM_DIRECT: addr_o = req_i.addr; // [RL5]
        AM_INDIRECT: addr_o = ptr;
        AM_DISP: addr_o = (req_i.ptr == PTR_X) ? ptr : ptr + {10'h000, req_i.disp}; // [RL6]
        AM_PREDEC: begin
          ptr_nxt_o = ptr - 16'h0001; // [RL7]
          ptr_we_o = 1'b1;
          addr_o = ptr - 16'h0001;
        end
        AM_POSTINC: begin
          ptr_nxt_o = ptr + 16'h0001; // [RL7]
          ptr_we_o = 1'b1;
          addr_o = ptr;
        end
        default: addr_o = req_i.addr;
      endcase
    end
    if (addr_o <= REGF_END) begin
      region_o = RG_REGF; // [RL1]
    end else if (addr_o <= STDIO_END) begin
      region_o = RG_STDIO; // [RL2]
    end else if (addr_o <= EXTIO_END) begin
      region_o = RG_EXTIO; // [RL3]
    end else if (addr_o <= SRAM_END) begin
      region_o = RG_SRAM; // [RL4]
    end else begin
      region_o = RG_NONE;
    end
  end
endmodule : dsd_agen
`default_nettype wire

// file: verilog/dsd_decoder.sv
// Operation
// RL1: Lowest 32 addresses reach working registers
// RL2: Next 64 addresses reach standard I/O
// RL3: Extended I/O reachable only by data accesses
// RL4: SRAM from 0x0100 up to variant end
// RL5: Direct addressing reaches whole data space
// RL6: Displacement reaches 63 past Y or Z
// RL7: Pre-decrement/post-increment update X, Y, Z pairs
// RL8: SRAM access takes two clock cycles
// RL9: I/O address plus 0x20 gives data address
// RL10: Bit instructions work on I/O 0x00-0x1F only
// RL11: Bit set/clear touches only addressed bit
// RL12: Some flags clear on writing one
// RL13: Nonvolatile read stalls CPU four cycles
// RL14: Nonvolatile write start stalls CPU two cycles
// RL15: Separate byte-wide nonvolatile space, 512B-2K
// RL16: Writes self-timed, completion visible to software
// RL17: Write starts only after arming sequence
// RL18: Reset lets an active write finish
// RL19: Software writes reserved bits as zero
// RL20: Arm clears after four cycles; trigger needs arm
// RL21: Trigger stays set until write time elapses
// RL22: Unmapped I/O reads zero, writes ignored
`timescale 1ns/1ns
`default_nettype none
module dsd_decoder import dsd_pkg::*; #(
  parameter int unsigned SRAM_BYTES = SRAM_BYTES_DEF,
  parameter int unsigned NV_BYTES = NV_BYTES_DEF,
  parameter int unsigned NVT_W = NVT_W_DEF,
  parameter int unsigned NV_ATOM_CYC = NV_ATOMIC_CYC,
  parameter int unsigned NV_SPL_CYC = NV_SPLIT_CYC
) (
  input wire logic clock_i, // CPU clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire dsd_req_t req_i, // Access request from CPU
  output dsd_rsp_t rsp_o, // Access answer
  output logic busy_o, // CPU stall
  output dsd_region_t region_o, // Region of last access
  output logic nv_busy_o // Nonvolatile write in progress
);
  localparam int unsigned SRAM_AW = $clog2(SRAM_BYTES);
  localparam int unsigned NV_AW = $clog2(NV_BYTES);
  localparam logic [NVT_W-1:0] ATOM_LD = NVT_W'(NV_ATOM_CYC);
  localparam logic [NVT_W-1:0] SPL_LD = NVT_W'(NV_SPL_CYC);
  localparam logic [NVT_W-1:0] TMR_ONE = NVT_W'(1);

  typedef enum logic [1:0] {ST_IDLE, ST_SRAM, ST_STALL} dsd_fsm_t;

  typedef struct packed {
    dsd_fsm_t fsm;
    logic [2:0] stall_cnt;
    logic sram_wr;
    logic [31:0][7:0] rf;
    logic [7:0] gpr;
    logic flag_done;
    logic nv_arm;
    logic [2:0] arm_cnt;
    logic nv_trig;
    logic [1:0] nv_mode;
    logic [NV_ADDR_W-1:0] nv_addr;
    logic [7:0] nv_data;
    logic [NVT_W-1:0] nv_tmr;
    logic nv_rd_pend;
    dsd_rsp_t rsp;
    logic busy;
    dsd_region_t region;
  } dsd_state_t;

  dsd_state_t s_r;
  dsd_state_t s_nxt;
  dsd_state_t s_rst;

  logic [15:0] ag_addr;
  dsd_region_t ag_region;
  logic ag_ptr_we;
  logic [4:0] ag_ptr_idx;
  logic [15:0] ag_ptr_nxt;
  logic sram_en;
  logic sram_we;
  logic [SRAM_AW-1:0] sram_addr;
  logic [7:0] sram_rdata;
  logic nv_we;
  logic [7:0] nv_wdata;
  logic [7:0] nv_rdata;

  function automatic logic [7:0] mwr(input logic [7:0] old, input logic [7:0] m,
                                     input logic [7:0] v);
    return (old & ~m) | (v & m);
  endfunction : mwr

  dsd_agen #(
    .SRAM_BYTES(SRAM_BYTES)
  ) u_agen (
    .req_i(req_i),
    .ptrs_i({s_r.rf[31], s_r.rf[30], s_r.rf[29], s_r.rf[28], s_r.rf[27], s_r.rf[26]}),
    .addr_o(ag_addr),
    .region_o(ag_region),
    .ptr_we_o(ag_ptr_we),
    .ptr_idx_o(ag_ptr_idx),
    .ptr_nxt_o(ag_ptr_nxt)
  );

  dsd_mem #(
    .WIDTH(8),
    .DEPTH(SRAM_BYTES)
  ) u_sram (
    .clock_i(clock_i),
    .en_i(sram_en),
    .we_i(sram_we),
    .addr_i(sram_addr),
    .wdata_i(req_i.wdata),
    .rdata_o(sram_rdata)
  );

  // Nonvolatile array reads continuously at the held address
  dsd_mem #(
    .WIDTH(8),
    .DEPTH(NV_BYTES)
  ) u_nvmem (
    .clock_i(clock_i),
    .en_i(1'b1),
    .we_i(nv_we),
    .addr_i(s_r.nv_addr[NV_AW-1:0]), // [RL15]
    .wdata_i(nv_wdata),
    .rdata_o(nv_rdata)
  );

  always_comb begin
    logic [7:0] wm;
    logic [7:0] wv;
    logic [7:0] wb;
    logic [7:0] rd;
    logic [15:0] io_ofs;
    logic [15:0] sram_ofs;
    logic [5:0] ioa;
    logic acc;
    logic bit_ok;
    logic done_set;
    wm = 8'h00;
    wv = 8'h00;
    wb = 8'h00;
    rd = 8'h00;
    io_ofs = ag_addr - STDIO_BASE;
    sram_ofs = ag_addr - SRAM_BASE;
    ioa = io_ofs[5:0];
    acc = 1'b0;
    bit_ok = 1'b0;
    done_set = 1'b0;
    s_nxt = s_r;
    s_nxt.rsp = '0;
    sram_en = 1'b0;
    sram_we = 1'b0;
    sram_addr = '0;
    nv_we = 1'b0;
    nv_wdata = s_r.nv_data;

    // Arm window
    if (s_r.nv_arm) begin
      if (s_r.arm_cnt == 3'h1) begin
        s_nxt.nv_arm = 1'b0; // [RL20]
      end else begin
        s_nxt.arm_cnt = s_r.arm_cnt - 3'h1;
      end
    end

    // Self-timed write
    if (s_r.nv_trig) begin
      if (s_r.nv_tmr == TMR_ONE) begin
        nv_we = 1'b1; // [RL16]
        s_nxt.nv_trig = 1'b0; // [RL21]
        done_set = 1'b1;
        unique case (dsd_nvmode_t'(s_r.nv_mode))
          NVM_ERASE: nv_wdata = 8'hFF;
          NVM_WRITE: nv_wdata = nv_rdata & s_r.nv_data;
          default: nv_wdata = s_r.nv_data;
        endcase
      end else begin
        s_nxt.nv_tmr = s_r.nv_tmr - TMR_ONE;
      end
    end

    unique case (s_r.fsm)
      ST_IDLE: acc = rst_n_i & req_i.valid;
      ST_SRAM: begin
        s_nxt.rsp.valid = 1'b1; // [RL8]
        s_nxt.rsp.rdata = s_r.sram_wr ? 8'h00 : sram_rdata;
        s_nxt.fsm = ST_IDLE;
      end
      ST_STALL: begin
        if (s_r.stall_cnt == 3'h1) begin
          s_nxt.fsm = ST_IDLE;
          if (s_r.nv_rd_pend) begin
            s_nxt.nv_data = nv_rdata;
            s_nxt.nv_rd_pend = 1'b0;
          end
        end else begin
          s_nxt.stall_cnt = s_r.stall_cnt - 3'h1;
        end
      end
    endcase

    if (acc) begin
      s_nxt.region = ag_region;
      bit_ok = req_i.io_form && (req_i.io_addr <= IO_BIT_END); // [RL10]
      case (req_i.bitop)
        BOP_SET, BOP_CLEAR: begin
          if (bit_ok) begin
            wm = 8'h01 << req_i.bit_idx; // [RL11]
            wv = (req_i.bitop == BOP_SET) ? wm : 8'h00;
          end
        end
        BOP_NONE: begin
          if (req_i.write) begin
            wm = 8'hFF;
            wv = req_i.wdata;
          end
        end
        default: ;
      endcase
      wb = wm & wv;
      if (ag_ptr_we) begin
        s_nxt.rf[ag_ptr_idx] = ag_ptr_nxt[7:0]; // [RL7]
        s_nxt.rf[ag_ptr_idx + 5'h01] = ag_ptr_nxt[15:8];
      end
      case (ag_region)
        RG_REGF: begin
          rd = s_r.rf[ag_addr[4:0]]; // [RL1]
          s_nxt.rf[ag_addr[4:0]] = mwr(s_nxt.rf[ag_addr[4:0]], wm, wv);
        end
        RG_STDIO: begin
          case (ioa) // [RL2]
            IO_FLAGS: begin
              rd = {7'h00, s_r.flag_done};
              if (wb[FLG_DONE]) begin
                s_nxt.flag_done = 1'b0; // [RL12]
              end
            end
            IO_GPR: begin
              rd = s_r.gpr;
              s_nxt.gpr = mwr(s_r.gpr, wm, wv);
            end
            IO_NV_CTRL: begin
              rd = {2'b00, s_r.nv_mode, 1'b0, s_r.nv_arm, s_r.nv_trig, 1'b0};
              if (!s_r.nv_trig) begin
                s_nxt.nv_mode = (s_r.nv_mode & ~wm[CTL_MODE_HI:CTL_MODE_LO]) |
                                (wv[CTL_MODE_HI:CTL_MODE_LO] & wm[CTL_MODE_HI:CTL_MODE_LO]);
              end
              if (wb[CTL_ARM]) begin
                s_nxt.nv_arm = 1'b1; // [RL17]
                s_nxt.arm_cnt = ARM_CYC; // [RL20]
              end
              if (wb[CTL_TRIG] && s_r.nv_arm && !s_r.nv_trig) begin
                s_nxt.nv_trig = 1'b1; // [RL17] [RL20] [RL21]
                s_nxt.nv_arm = 1'b0;
                s_nxt.nv_tmr = (s_nxt.nv_mode == NVM_ERASE || s_nxt.nv_mode == NVM_WRITE) ?
                               SPL_LD : ATOM_LD; // [RL16]
                s_nxt.fsm = ST_STALL;
                s_nxt.stall_cnt = NV_WR_STALL; // [RL14]
              end else if (wb[CTL_READ] && !s_r.nv_trig) begin
                s_nxt.nv_rd_pend = 1'b1;
                s_nxt.fsm = ST_STALL;
                s_nxt.stall_cnt = NV_RD_STALL; // [RL13]
              end
            end
            IO_NV_DATA: begin
              rd = s_r.nv_data;
              s_nxt.nv_data = mwr(s_r.nv_data, wm, wv);
            end
            IO_NV_ALO: begin
              rd = s_r.nv_addr[7:0];
              if (!s_r.nv_trig) begin
                s_nxt.nv_addr[7:0] = mwr(s_r.nv_addr[7:0], wm, wv);
              end
            end
            IO_NV_AHI: begin
              rd = {5'h00, s_r.nv_addr[10:8]};
              if (!s_r.nv_trig) begin
                s_nxt.nv_addr[10:8] = (s_r.nv_addr[10:8] & ~wm[2:0]) | (wv[2:0] & wm[2:0]);
              end
            end
            default: rd = 8'h00; // [RL22]
          endcase
        end
        RG_SRAM: begin
          sram_en = 1'b1; // [RL4]
          sram_we = |wm;
          sram_addr = sram_ofs[SRAM_AW-1:0];
          s_nxt.sram_wr = |wm;
          s_nxt.fsm = ST_SRAM; // [RL8]
        end
        default: rd = 8'h00; // [RL22]
      endcase
      if (ag_region != RG_SRAM) begin
        s_nxt.rsp.valid = 1'b1;
        s_nxt.rsp.rdata = (|wm || req_i.write) ? 8'h00 : rd;
        s_nxt.rsp.skip = bit_ok && ((req_i.bitop == BOP_SKIP_SET && rd[req_i.bit_idx]) ||
                         (req_i.bitop == BOP_SKIP_CLEAR && !rd[req_i.bit_idx]));
      end
    end

    // Hardware set beats a same-cycle software clear
    if (done_set) begin
      s_nxt.flag_done = 1'b1;
    end
    s_nxt.busy = (s_nxt.fsm != ST_IDLE);

    s_rst = '0;
    s_rst.gpr = GPR_RST;
    s_rst.nv_data = NV_DATA_RST;
    s_rst.nv_mode = NV_MODE_RST;
    s_rst.region = RG_NONE;
    if (s_r.nv_trig) begin
      s_rst.nv_trig = s_nxt.nv_trig; // [RL18]
      s_rst.nv_tmr = s_nxt.nv_tmr;
      s_rst.nv_mode = s_r.nv_mode;
      s_rst.nv_addr = s_r.nv_addr;
      s_rst.nv_data = s_r.nv_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_r <= s_rst;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp_o = s_r.rsp;
  assign busy_o = s_r.busy;
  assign region_o = s_r.region;
  assign nv_busy_o = s_r.nv_trig;
endmodule : dsd_decoder
`default_nettype wire

// file: verilog/dsd_mem.sv
`timescale 1ns/1ns
`default_nettype none
module dsd_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clock_i, // Clock
  input wire logic en_i, // Access enable
  input wire logic we_i, // Write enable
  input wire logic [AW-1:0] addr_i, // Word address
  input wire logic [WIDTH-1:0] wdata_i, // Write data
  output logic [WIDTH-1:0] rdata_o // Registered read data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // Read returns the old word on a write cycle
  always_ff @(posedge clock_i) begin
    if (en_i) begin
      if (we_i) begin
        mem_r[addr_i] <= wdata_i;
      end
      rdata_o <= mem_r[addr_i];
    end
  end
endmodule : dsd_mem
`default_nettype wire
